// ### src/udc_regs.svh
`ifndef UDC_REGS_SVH
`define UDC_REGS_SVH
`define UDC_IDX_TX_STATUS 16'hFFE1
`define UDC_IDX_RX_DEF 16'hFFE4
`define UDC_IDX_TX_DEF 16'hFFF0
`define UDC_IDX_TX_TIMEOUT 16'hFFF1
`define UDC_IDX_TX_COMPLETION 16'hFFF2
`define UDC_IDX_PAD 14'h0000
`define UDC_LANE_PAD 2'h0
`define UDC_BIT_ENABLE 7
`define UDC_BIT_IRQ_EN 6
`define UDC_BIT_CONT 5
`define UDC_BIT_XY 4
`define UDC_BIT_DIR 3
`define UDC_EDB_HI 2
`define UDC_EDB_LO 0
`define UDC_BIT_PARTIAL_PACKET_FLAG 0
`define UDC_RST_BYTE 8'h00
`define UDC_RST_EDB 3'h0
`define UDC_DIR_RX 1'b1
`define UDC_CLK_NS 5
`define UDC_TO_UNIT_NS 1000
`define UDC_TO_UNIT_CYC (`UDC_TO_UNIT_NS / `UDC_CLK_NS)
`define UDC_FIFO_WIDTH 8
`define UDC_FIFO_DEPTH 8
`endif

// ### src/udc_pkg.sv
package udc_pkg;
    typedef enum logic [2:0] {
        UDC_CAUSE_NONE,
        UDC_CAUSE_DONE,
        UDC_CAUSE_TIMEOUT,
        UDC_CAUSE_ERROR,
        UDC_CAUSE_PARTIAL
    } udc_cause_t;
endpackage : udc_pkg

// ### src/udc_top.sv
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "udc_regs.svh"

module udc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];
    localparam logic [AW:0] ONE = {{AW{1'b0}}, 1'b1};
    localparam logic [AW-1:0] LAST = DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [AW:0] count_next;
    logic push;
    logic pop;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_reg];
    always_comb begin
        count_next = count_reg;
        if (push & ~pop) begin
            count_next = count_reg + ONE;
        end else if (pop & ~push) begin
            count_next = count_reg - ONE;
        end
    end
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            in_ready <= (count_next != FULL_COUNT);
            out_valid <= (count_next != '0);
        end
    end
endmodule : udc_fifo

// Function
// RULE1: the transmit status side reports how the last transfer ended, beside its time-out setting.
// RULE2: the partial-packet flag in bit 0 is set only by the channel on a short packet and cleared only by software.
// RULE3: writing 1 to the partial-packet flag clears it and writing 0 leaves it alone.
// RULE4: with the completion interrupt enable at 0 a short packet does not drop the transmit enable.
// RULE5: bits 7 to 1 of the transmit status register read as zero and ignore writes.
// RULE6: the receive definition register selects the descriptor block used for serial receive data.
// RULE7: the receive definition register shows the direction and holds the X or Y buffer selector.
// RULE8: software sets enable to start, the channel clears it on completion or error, and the fall interrupts if enabled. Receive clears only on rx_error.
// RULE9: buffer select 0 picks buffer X and 1 picks buffer Y as the next buffer.
// RULE10: software always writes the continuous-mode bit as 1 so buffers alternate on their own.
// RULE11: the receive direction bit always reads 1 and bits 2 to 0 point at the descriptor set.
// RULE12: the receive register fields reset to zero except the direction bit, which is one.
module udc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic uart_rx_valid,
    output logic uart_rx_ready,
    input wire logic [7:0] uart_rx_data,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [7:0] mem_wr_data,
    output logic [2:0] rx_endpoint_descriptor_block,
    output logic rx_buffer_select,
    output logic rx_active,
    input wire logic rx_buffer_swap,
    input wire logic rx_error,
    output logic [2:0] tx_endpoint_descriptor_block,
    output logic tx_buffer_select,
    output logic tx_active,
    input wire logic tx_activity,
    input wire logic tx_buffer_done,
    input wire logic tx_short_packet,
    input wire logic tx_done,
    input wire logic tx_error,
    output logic completion_irq
);
    localparam logic [7:0] TO_UNIT_LAST = 8'(`UDC_TO_UNIT_CYC - 1);

    logic [31:0] addr_tx_status;
    logic [31:0] addr_rx_def;
    logic [31:0] addr_tx_def;
    logic [31:0] addr_tx_timeout;
    logic [31:0] addr_tx_completion;
    logic hit_tx_status;
    logic hit_rx_def;
    logic hit_tx_def;
    logic hit_tx_timeout;
    logic hit_tx_completion;
    logic mapped;
    logic access;
    logic wr_commit;
    logic [7:0] rdata_byte;

    logic partial_packet_flag_reg;
    logic tx_en_reg;
    logic tx_irq_en_reg;
    logic tx_cont_reg;
    logic tx_xy_reg;
    logic [2:0] tx_edb_reg;
    logic [7:0] tx_timeout_reg;
    udc_pkg::udc_cause_t tx_cause_reg;
    logic tx_en_d_reg;
    logic rx_en_reg;
    logic rx_irq_en_reg;
    logic rx_cont_reg;
    logic rx_xy_reg;
    logic [2:0] rx_edb_reg;
    logic rx_en_d_reg;
    logic [7:0] prescale_reg;
    logic [7:0] unit_cnt_reg;
    logic timeout_hit;
    logic tx_short_term;
    logic tx_term;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    assign addr_tx_status = {`UDC_IDX_PAD, `UDC_IDX_TX_STATUS, `UDC_LANE_PAD};
    assign addr_rx_def = {`UDC_IDX_PAD, `UDC_IDX_RX_DEF, `UDC_LANE_PAD};
    assign addr_tx_def = {`UDC_IDX_PAD, `UDC_IDX_TX_DEF, `UDC_LANE_PAD};
    assign addr_tx_timeout = {`UDC_IDX_PAD, `UDC_IDX_TX_TIMEOUT, `UDC_LANE_PAD};
    assign addr_tx_completion = {`UDC_IDX_PAD, `UDC_IDX_TX_COMPLETION, `UDC_LANE_PAD};
    assign hit_tx_status = (paddr == addr_tx_status);
    assign hit_rx_def = (paddr == addr_rx_def);
    assign hit_tx_def = (paddr == addr_tx_def);
    assign hit_tx_timeout = (paddr == addr_tx_timeout);
    assign hit_tx_completion = (paddr == addr_tx_completion);
    assign mapped = hit_tx_status | hit_rx_def | hit_tx_def | hit_tx_timeout | hit_tx_completion;
    assign access = psel & penable;
    // writes land only at the edge that completes the access
    assign wr_commit = access & pready & pwrite & mapped;

    always_comb begin
        rdata_byte = `UDC_RST_BYTE;
        if (hit_tx_status) begin
            rdata_byte[`UDC_BIT_PARTIAL_PACKET_FLAG] = partial_packet_flag_reg; // RULE5
        end else if (hit_rx_def) begin
            rdata_byte[`UDC_BIT_ENABLE] = rx_en_reg;
            rdata_byte[`UDC_BIT_IRQ_EN] = rx_irq_en_reg;
            rdata_byte[`UDC_BIT_CONT] = rx_cont_reg;
            rdata_byte[`UDC_BIT_XY] = rx_xy_reg; // RULE7
            rdata_byte[`UDC_BIT_DIR] = `UDC_DIR_RX; // RULE11
            rdata_byte[`UDC_EDB_HI:`UDC_EDB_LO] = rx_edb_reg; // RULE6
        end else if (hit_tx_def) begin
            rdata_byte[`UDC_BIT_ENABLE] = tx_en_reg;
            rdata_byte[`UDC_BIT_IRQ_EN] = tx_irq_en_reg;
            rdata_byte[`UDC_BIT_CONT] = tx_cont_reg;
            rdata_byte[`UDC_BIT_XY] = tx_xy_reg;
            rdata_byte[`UDC_EDB_HI:`UDC_EDB_LO] = tx_edb_reg;
        end else if (hit_tx_timeout) begin
            rdata_byte = tx_timeout_reg; // RULE1
        end else if (hit_tx_completion) begin
            rdata_byte[2:0] = tx_cause_reg; // RULE1
        end
    end

    // apb answer: pready one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access & ~pready;
            if (access & ~pready) begin
                pslverr <= ~mapped;
                prdata <= pwrite ? 32'h00000000 : {24'h000000, rdata_byte};
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // transmit time-out, counted in units of a microsecond
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_reg <= `UDC_RST_BYTE;
            unit_cnt_reg <= `UDC_RST_BYTE;
        end else if (!tx_en_reg || tx_activity || tx_timeout_reg == `UDC_RST_BYTE) begin
            prescale_reg <= `UDC_RST_BYTE;
            unit_cnt_reg <= `UDC_RST_BYTE;
        end else if (prescale_reg == TO_UNIT_LAST) begin
            prescale_reg <= `UDC_RST_BYTE;
            if (!timeout_hit) begin
                unit_cnt_reg <= unit_cnt_reg + 8'h01;
            end
        end else begin
            prescale_reg <= prescale_reg + 8'h01;
        end
    end

    assign timeout_hit = (tx_timeout_reg != `UDC_RST_BYTE) && (unit_cnt_reg == tx_timeout_reg);
    assign tx_short_term = tx_short_packet & tx_irq_en_reg; // RULE4
    assign tx_term = tx_en_reg & (tx_done | tx_error | timeout_hit | tx_short_term); // RULE8

    // partial-packet flag: set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            partial_packet_flag_reg <= 1'b0;
        end else if (tx_en_reg & tx_short_packet) begin
            partial_packet_flag_reg <= 1'b1; // RULE2
        end else if (wr_commit & hit_tx_status & pwdata[`UDC_BIT_PARTIAL_PACKET_FLAG]) begin
            partial_packet_flag_reg <= 1'b0; // RULE3
        end
    end

    // transmit definition and time-out setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_en_reg <= 1'b0;
            tx_irq_en_reg <= 1'b0;
            tx_cont_reg <= 1'b0;
            tx_xy_reg <= 1'b0;
            tx_edb_reg <= `UDC_RST_EDB;
            tx_timeout_reg <= `UDC_RST_BYTE;
        end else begin
            if (wr_commit & hit_tx_def) begin
                tx_en_reg <= pwdata[`UDC_BIT_ENABLE];
                tx_irq_en_reg <= pwdata[`UDC_BIT_IRQ_EN];
                tx_cont_reg <= pwdata[`UDC_BIT_CONT];
                tx_xy_reg <= pwdata[`UDC_BIT_XY];
                tx_edb_reg <= pwdata[`UDC_EDB_HI:`UDC_EDB_LO];
            end else if (tx_en_reg & tx_cont_reg & tx_buffer_done) begin
                tx_xy_reg <= ~tx_xy_reg; // RULE10
            end
            if (tx_term) begin
                tx_en_reg <= 1'b0; // RULE8
            end
            if (wr_commit & hit_tx_timeout) begin
                tx_timeout_reg <= pwdata[7:0];
            end
        end
    end

    // completion code of the last transmit run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cause_reg <= udc_pkg::UDC_CAUSE_NONE;
        end else if (tx_en_reg) begin
            if (tx_error) begin
                tx_cause_reg <= udc_pkg::UDC_CAUSE_ERROR; // RULE1
            end else if (timeout_hit) begin
                tx_cause_reg <= udc_pkg::UDC_CAUSE_TIMEOUT; // RULE1
            end else if (tx_short_term) begin
                tx_cause_reg <= udc_pkg::UDC_CAUSE_PARTIAL;
            end else if (tx_done) begin
                tx_cause_reg <= udc_pkg::UDC_CAUSE_DONE;
            end
        end else if (wr_commit & hit_tx_def & pwdata[`UDC_BIT_ENABLE]) begin
            tx_cause_reg <= udc_pkg::UDC_CAUSE_NONE;
        end
    end

    // receive definition register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_en_reg <= 1'b0; // RULE12
            rx_irq_en_reg <= 1'b0;
            rx_cont_reg <= 1'b0;
            rx_xy_reg <= 1'b0;
            rx_edb_reg <= `UDC_RST_EDB;
        end else begin
            if (wr_commit & hit_rx_def) begin
                rx_en_reg <= pwdata[`UDC_BIT_ENABLE];
                rx_irq_en_reg <= pwdata[`UDC_BIT_IRQ_EN];
                rx_cont_reg <= pwdata[`UDC_BIT_CONT];
                rx_xy_reg <= pwdata[`UDC_BIT_XY]; // RULE7
                rx_edb_reg <= pwdata[`UDC_EDB_HI:`UDC_EDB_LO]; // RULE6
            end else if (rx_en_reg & rx_cont_reg & rx_buffer_swap) begin
                rx_xy_reg <= ~rx_xy_reg; // RULE10
            end
            if (rx_en_reg & rx_error) begin
                rx_en_reg <= 1'b0; // RULE8
            end
        end
    end

    // interrupt pulse on a falling enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_en_d_reg <= 1'b0;
            rx_en_d_reg <= 1'b0;
            completion_irq <= 1'b0;
        end else begin
            tx_en_d_reg <= tx_en_reg;
            rx_en_d_reg <= rx_en_reg;
            completion_irq <= (tx_en_d_reg & ~tx_en_reg & tx_irq_en_reg) |
                (rx_en_d_reg & ~rx_en_reg & rx_irq_en_reg); // RULE8
        end
    end

    // channel selections seen by the buffer manager
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_endpoint_descriptor_block <= `UDC_RST_EDB;
            rx_buffer_select <= 1'b0;
            rx_active <= 1'b0;
            tx_endpoint_descriptor_block <= `UDC_RST_EDB;
            tx_buffer_select <= 1'b0;
            tx_active <= 1'b0;
        end else begin
            rx_endpoint_descriptor_block <= rx_edb_reg; // RULE6
            rx_buffer_select <= rx_xy_reg; // RULE9
            rx_active <= rx_en_reg;
            tx_endpoint_descriptor_block <= tx_edb_reg;
            tx_buffer_select <= tx_xy_reg; // RULE9
            tx_active <= tx_en_reg;
        end
    end

    udc_fifo #(
        .WIDTH(`UDC_FIFO_WIDTH),
        .DEPTH(`UDC_FIFO_DEPTH)
    ) u_rx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(uart_rx_valid),
        .in_ready(uart_rx_ready),
        .in_data(uart_rx_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // output stage toward buffer memory, drains only while receive is enabled
    assign fifo_out_ready = rx_en_reg & (~mem_wr_valid | mem_wr_ready);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_wr_valid <= 1'b0;
            mem_wr_data <= `UDC_RST_BYTE;
        end else if (fifo_out_ready & fifo_out_valid) begin
            mem_wr_valid <= 1'b1;
            mem_wr_data <= fifo_out_data;
        end else if (mem_wr_ready) begin
            mem_wr_valid <= 1'b0;
        end
    end
endmodule : udc_top

// ### verif/udc_top_monitor.sv
`timescale 1ns/100ps
module udc_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_wr_valid,
    input wire logic mem_wr_ready,
    input wire logic [7:0] mem_wr_data,
    input wire logic [2:0] rx_endpoint_descriptor_block,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic tx_done,
    input wire logic completion_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped, xfer, rd_done;
    logic [2:0] wr_edb;
    assign mapped = paddr inside {32'h0003FF84, 32'h0003FF90, 32'h0003FFC0, 32'h0003FFC4,
        32'h0003FFC8};
    assign xfer = psel && penable && pready;
    assign rd_done = xfer && !pwrite;
    assign wr_edb = pwdata[2:0];
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_one_wait; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
    a_one_wait: assert property (p_one_wait) else $error("apb wait state count wrong");
    property p_slverr; xfer |-> pslverr == !mapped && (mapped || pwrite || prdata == 32'h0); endproperty
    a_slverr: assert property (p_slverr) else $error("apb error response wrong");
    property p_txs_read; rd_done && paddr == 32'h0003FF84 |-> prdata[31:1] == 31'h0; endproperty
    a_txs_read: assert property (p_txs_read) else $error("tx status upper bits set");
    property p_rxd_read; rd_done && paddr == 32'h0003FF90 |-> prdata[3] && prdata[31:8] == 24'h0;
    endproperty
    a_rxd_read: assert property (p_rxd_read) else $error("rx def direction bit wrong");
    property p_rx_edb;
        xfer && pwrite && paddr == 32'h0003FF90 |-> ##2 rx_endpoint_descriptor_block == $past(wr_edb, 2);
    endproperty
    a_rx_edb: assert property (p_rx_edb) else $error("rx descriptor output wrong");
    property p_irq_cause;
        completion_irq |-> (!tx_active && ($past(tx_active) || $past(tx_active, 2) ||
            $past(tx_active, 3))) || (!rx_active && ($past(rx_active) || $past(rx_active, 2) ||
            $past(rx_active, 3)));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without enable fall");
    property p_tx_end; tx_active && tx_done |-> ##[1:3] !tx_active; endproperty
    a_tx_end: assert property (p_tx_end) else $error("tx run not ended");
    property p_stream_hold; mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_data);
    endproperty
    a_stream_hold: assert property (p_stream_hold) else $error("stream output dropped");
endmodule : udc_top_chk
bind udc_top udc_top_chk udc_top_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_data(mem_wr_data), .rx_endpoint_descriptor_block(rx_endpoint_descriptor_block),
    .rx_active(rx_active), .tx_active(tx_active), .tx_done(tx_done),
    .completion_irq(completion_irq));

// ### verif/udc_mem_sink.sv
`timescale 1ns/100ps
module udc_mem_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic mem_wr_valid,
    input wire logic [7:0] mem_wr_data,
    output logic mem_wr_ready
);
    logic [7:0] got[$];
    logic toggle_reg;
    // ready only every other cycle: a slow buffer manager
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) toggle_reg <= 1'b0;
        else toggle_reg <= !toggle_reg;
    end
    assign mem_wr_ready = !stall && toggle_reg;
    always @(posedge pclk) begin
        if (presetn && mem_wr_valid && mem_wr_ready) got.push_back(mem_wr_data);
    end
endmodule : udc_mem_sink

// ### verif/tb_udc_top.sv
`timescale 1ns/100ps
`include "udc_regs.svh"
module tb_udc_top;
    localparam logic [31:0] A_TXS = `UDC_IDX_TX_STATUS * 4;
    localparam logic [31:0] A_RXD = `UDC_IDX_RX_DEF * 4;
    localparam logic [31:0] A_TXD = `UDC_IDX_TX_DEF * 4;
    localparam logic [31:0] A_TXC = `UDC_IDX_TX_COMPLETION * 4;
    localparam logic [31:0] A_TXO = `UDC_IDX_TX_TIMEOUT * 4;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, uart_rx_ready, mem_wr_valid, mem_wr_ready, rx_buffer_select, rx_active;
    logic tx_buffer_select, tx_active, completion_irq, stall = 1'b0, uart_rx_valid = 1'b0;
    logic [7:0] uart_rx_data = 8'h30, mem_wr_data;
    logic [2:0] rx_endpoint_descriptor_block, tx_endpoint_descriptor_block;
    logic [6:0] ev = 7'h00;
    int bad_count = 0, total_checks = 0, n;
    udc_top udc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .uart_rx_valid(uart_rx_valid), .uart_rx_ready(uart_rx_ready),
        .uart_rx_data(uart_rx_data), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
        .mem_wr_data(mem_wr_data), .rx_endpoint_descriptor_block(rx_endpoint_descriptor_block),
        .rx_buffer_select(rx_buffer_select), .rx_active(rx_active), .rx_buffer_swap(ev[4]),
        .rx_error(ev[0]), .tx_endpoint_descriptor_block(tx_endpoint_descriptor_block),
        .tx_buffer_select(tx_buffer_select), .tx_active(tx_active), .tx_activity(ev[6]),
        .tx_buffer_done(ev[5]), .tx_short_packet(ev[1]), .tx_done(ev[2]), .tx_error(ev[3]),
        .completion_irq(completion_irq));
    udc_mem_sink udc_mem_sink_i (.pclk(pclk), .presetn(presetn), .stall(stall),
        .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready));
    initial forever #2.5 pclk = ~pclk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        chk("pready", pready, 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic xe, input string nm);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, q, x);
        chk({nm, " error"}, e, xe);
    endtask : rd
    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
    endtask : pulse
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        #100000;
        bad_count++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_TXS, 32'h0, 1'b0, "tx status reset");
        rd(A_RXD, 32'h08, 1'b0, "rx def reset");
        rd(32'h0003FF88, 32'h0, 1'b1, "unmapped");
        $display("test reset done");
        wr(A_RXD, 32'hFFFFFF77);
        rd(A_RXD, 32'h7F, 1'b0, "rx def y");
        chk("rx edb", rx_endpoint_descriptor_block, 32'h7);
        chk("rx select y", rx_buffer_select, 32'h1);
        wr(A_RXD, 32'h20);
        rd(A_RXD, 32'h28, 1'b0, "rx def x");
        chk("rx select x", rx_buffer_select, 32'h0);
        $display("test rx def done");
        wr(A_TXD, 32'hA0);
        pulse(1);
        rd(A_TXS, 32'h1, 1'b0, "partial set");
        chk("tx still on", tx_active, 32'h1);
        wr(A_TXS, 32'hFE);
        rd(A_TXS, 32'h1, 1'b0, "write zero");
        wr(A_TXS, 32'h01);
        rd(A_TXS, 32'h0, 1'b0, "w1c");
        pulse(2);
        rd(A_TXD, 32'h20, 1'b0, "tx done clears en");
        rd(A_TXC, 32'h1, 1'b0, "code done");
        wr(A_TXD, 32'hE0);
        pulse(3);
        n = 0;
        while (completion_irq !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        chk("irq", completion_irq, 32'h1);
        rd(A_TXC, 32'h3, 1'b0, "code error");
        wr(A_TXO, 32'h01);
        rd(A_TXO, 32'h01, 1'b0, "timeout setting");
        wr(A_TXD, 32'hA5);
        pulse(5);
        repeat (2) @(posedge pclk);
        chk("tx edb", tx_endpoint_descriptor_block, 32'h5);
        chk("tx select y", tx_buffer_select, 32'h1);
        repeat (150) @(posedge pclk);
        pulse(6);
        repeat (150) @(posedge pclk);
        chk("activity restarts", tx_active, 32'h1);
        repeat (150) @(posedge pclk);
        rd(A_TXC, 32'h2, 1'b0, "code timeout");
        rd(A_TXD, 32'h35, 1'b0, "timeout clears en");
        wr(A_TXD, 32'hE0);
        pulse(1);
        rd(A_TXD, 32'h60, 1'b0, "partial ends run");
        rd(A_TXC, 32'h4, 1'b0, "code partial");
        $display("test tx done");
        wr(A_RXD, 32'hA0);
        stall <= 1'b1;
        uart_rx_valid <= 1'b1;
        n = 0;
        repeat (14) begin
            @(posedge pclk);
            if (uart_rx_ready === 1'b1) begin
                n++;
                uart_rx_data <= uart_rx_data + 8'h01;
            end
        end
        uart_rx_valid <= 1'b0;
        chk("full refuses", uart_rx_ready, 32'h0);
        chk("held at least 8", 32'(n >= 8), 32'h1);
        pulse(4);
        repeat (2) @(posedge pclk);
        chk("swap", rx_buffer_select, 32'h1);
        stall <= 1'b0;
        repeat (200) @(posedge pclk);
        chk("drained", udc_mem_sink_i.got.size(), n);
        foreach (udc_mem_sink_i.got[i]) chk("byte", udc_mem_sink_i.got[i], 32'h30 + i);
        pulse(0);
        rd(A_RXD, 32'h38, 1'b0, "rx error clears en");
        chk("rx stopped", rx_active, 32'h0);
        $display("test stream done");
        test_done();
    end
endmodule : tb_udc_top
